/* File: logic/lrb_regs_defs.vh */
// register offsets, field positions and defaults of the select/enable bank
`ifndef LRB_REGS_DEFS_VH
`define LRB_REGS_DEFS_VH
`define LRB_ADDR_PART_ID 7'h00
`define LRB_ADDR_SI_REV 7'h01
`define LRB_ADDR_DEV_SEL 7'h03
`define LRB_ADDR_EN_CTRL 7'h07
`define LRB_ADDR_ADC_DATA 7'h43
`define LRB_KEY_VALUE 8'h03
`define LRB_SEL_RESET 8'h00
`define LRB_EN_RESET 8'h00
`define LRB_BIT_SOFT_RST 7
`define LRB_BIT_PRELOAD 6
`define LRB_BIT_OT_SHDN 5
`define LRB_BIT_SAMPLER 4
`define LRB_BIT_ADC 3
`define LRB_BIT_HEATER 2
`define LRB_BIT_DRIVER 1
`define LRB_BIT_CHIP 0
`define LRB_SYNC_RESET 3'h0
`define LRB_SYNC_IDLE_HI 3'h7
`define LRB_CNT_ZERO 4'h0
`define LRB_CNT_LAST 4'h7
`endif

/* File: logic/lrb_spi_regs.v */
// spi slave holding part id, revision, device-select key and enable control
// Functional notes
// - Address 0x00 reads a fixed part identifier and ignores writes.
// - Address 0x01 reads a revision code that is a parameter per version.
// - The serial port only serves accesses after the key 0x03 is written.
// - The port stays active while the select register holds the key.
// - Without the key only a write to the select register is accepted.
// - A write other than to the select register is held pending and only committed by the following read.
// - Writing one to the soft-reset bit reloads every register default.
// - Writing zero to the soft-reset bit does nothing.
// - Setting the preload bit snapshots the live ADC result for reading.
// - Thermal shutdown occurs on over-temperature only when enabled.
// - The sampler enable bit turns the sampler on, default off.
// - The ADC enable bit turns the ADC on, default off.
// - The heater enable bit turns the heater on, default off.
// - The driver-core enable bit turns the driver on, default off.
// - The whole-chip enable bit turns the device on, default off.
`timescale 1ns/1ps
`include "lrb_regs_defs.vh"
module lrb_spi_regs #(
  parameter [7:0] PART_ID = 8'hA5, // arbitrary value
  parameter [7:0] SI_REV = 8'h5A // arbitrary value
) (
  input wire clock,
  input wire rstn,
  input wire spiSclk,
  input wire spiCsn,
  input wire spiMosi,
  output reg spiMiso,
  output wire spiMisoOe,
  input wire [7:0] adcResult,
  input wire overTemp,
  output reg [7:0] enableCtrl,
  output wire samplerOn,
  output wire adcOn,
  output wire heaterOn,
  output wire driver_core_on,
  output wire chipOn,
  output reg thermalShutdown,
  output reg portActive
);

  //////////////////////////////////////////////////////////////////////
  // three-stage synchronisers; decisions use stages two and three
  // pins move on the host's clock, so nothing reads them raw
  reg [2:0] sclkSync_r;
  reg [2:0] csnSync_r;
  reg [2:0] mosiSync_r;

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sclkSync_r <= `LRB_SYNC_RESET;
      csnSync_r <= `LRB_SYNC_IDLE_HI;
      mosiSync_r <= `LRB_SYNC_RESET;
    end else begin
      sclkSync_r <= {sclkSync_r[1:0], spiSclk};
      csnSync_r <= {csnSync_r[1:0], spiCsn};
      mosiSync_r <= {mosiSync_r[1:0], spiMosi};
    end
  end

  // filtered levels: change once stages two and three agree
  // a one-stage glitch never reaches the frame logic
  reg sclkLvl_r;
  reg csnLvl_r;
  reg mosiLvl_r;

  // serial clock level
  always @(posedge clock or negedge rstn) begin
    if (!rstn)
      sclkLvl_r <= 1'b0;
    else if (sclkSync_r[1] == sclkSync_r[2])
      sclkLvl_r <= sclkSync_r[2];
  end

  // chip select level, idle high
  always @(posedge clock or negedge rstn) begin
    if (!rstn)
      csnLvl_r <= 1'b1;
    else if (csnSync_r[1] == csnSync_r[2])
      csnLvl_r <= csnSync_r[2];
  end

  // data-in level
  always @(posedge clock or negedge rstn) begin
    if (!rstn)
      mosiLvl_r <= 1'b0;
    else if (mosiSync_r[1] == mosiSync_r[2])
      mosiLvl_r <= mosiSync_r[2];
  end

  // edge toward pol once stages two and three agree on it
  function edgeSeen;
    input [2:0] sync;
    input lvl;
    input pol;
    begin
      edgeSeen = (sync[1] == sync[2]) && (sync[2] == pol) &&
                 (lvl != pol);
    end
  endfunction

  // one-clock strobes from the filtered levels
  wire sclkRise = edgeSeen(sclkSync_r, sclkLvl_r, 1'b1);
  wire sclkFall = edgeSeen(sclkSync_r, sclkLvl_r, 1'b0);
  // chip select falling opens a frame
  wire frameStart = edgeSeen(csnSync_r, csnLvl_r, 1'b0);
  wire frameActive = !csnLvl_r;

  //////////////////////////////////////////////////////////////////////
  // frame: bit0 r/w (1 = read), 7 address bits, 8 data bits, msb first
  // a frame with fewer than sixteen rises is thrown away
  // bit counter within the current byte
  reg [3:0] bitCnt_r;
  reg phaseData_r;
  reg [7:0] shiftIn_r;
  reg isRead_r;
  reg [6:0] addr_r;
  reg [7:0] shiftOut_r;
  reg frameDone_r;
  reg [7:0] dataIn_r;

  // soft-reset and live registers
  reg [7:0] devSel_r;
  reg [7:0] adcHold_r;
  reg pendValid_r;
  reg [6:0] pendAddr_r;
  reg [7:0] pendData_r;

  // port served only while the key is held
  wire keyOk = (devSel_r == `LRB_KEY_VALUE);
  // soft reset lasts one clock: it clears its own bit
  wire softRst = enableCtrl[`LRB_BIT_SOFT_RST];

  //////////////////////////////////////////////////////////////////////
  // readback decode; read-only entries ignore writes
  function [7:0] readMux;
    input [6:0] a;
    begin
      case (a)
        `LRB_ADDR_PART_ID: readMux = PART_ID;
        `LRB_ADDR_SI_REV: readMux = SI_REV;
        `LRB_ADDR_DEV_SEL: readMux = devSel_r;
        `LRB_ADDR_EN_CTRL: readMux = enableCtrl;
        `LRB_ADDR_ADC_DATA: readMux = enableCtrl[`LRB_BIT_PRELOAD] ?
                                      adcHold_r : adcResult;
        // unmapped reads return zero
        default: readMux = 8'h00;
      endcase
    end
  endfunction

  //////////////////////////////////////////////////////////////////////
  // serial shift engine
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bitCnt_r <= `LRB_CNT_ZERO;
      phaseData_r <= 1'b0;
      shiftIn_r <= 8'h00;
      isRead_r <= 1'b0;
      addr_r <= 7'h00;
      shiftOut_r <= 8'h00;
      frameDone_r <= 1'b0;
      dataIn_r <= 8'h00;
    end else begin
      frameDone_r <= 1'b0;
      if (frameStart || !frameActive) begin
        // new or cut frame: partial bits are dropped
        bitCnt_r <= `LRB_CNT_ZERO;
        phaseData_r <= 1'b0;
      end else if (sclkRise) begin
        shiftIn_r <= {shiftIn_r[6:0], mosiLvl_r};
        bitCnt_r <= bitCnt_r + 4'h1;
        if (bitCnt_r == `LRB_CNT_LAST && !phaseData_r) begin
          // command byte complete
          isRead_r <= shiftIn_r[6];
          addr_r <= {shiftIn_r[5:0], mosiLvl_r};
          phaseData_r <= 1'b1;
          bitCnt_r <= `LRB_CNT_ZERO;
          // locked port returns zeros
          // register sampled once, at the end of the command byte
          shiftOut_r <= keyOk ? readMux({shiftIn_r[5:0], mosiLvl_r})
                              : 8'h00;
        end else if (bitCnt_r == `LRB_CNT_LAST && phaseData_r) begin
          // data byte complete
          dataIn_r <= {shiftIn_r[6:0], mosiLvl_r};
          frameDone_r <= 1'b1;
          phaseData_r <= 1'b0;
          bitCnt_r <= `LRB_CNT_ZERO;
        end
      end else if (sclkFall && phaseData_r &&
                   bitCnt_r != `LRB_CNT_ZERO) begin
        // msb first out, one bit per fall
        shiftOut_r <= {shiftOut_r[6:0], 1'b0};
      end
    end
  end

  // miso driven only in data phase of a served read
  // one clock behind the shift register, well inside a half period
  always @(posedge clock or negedge rstn) begin
    if (!rstn)
      spiMiso <= 1'b0;
    else
      spiMiso <= shiftOut_r[7];
  end
  assign spiMisoOe = frameActive && phaseData_r && isRead_r && keyOk;

  //////////////////////////////////////////////////////////////////////
  // commit logic
  wire writeDone = frameDone_r && !isRead_r;
  wire readDone = frameDone_r && isRead_r;
  // select register always writable
  // it lands at frame end so the key can open the port
  wire selWrite = writeDone && (addr_r == `LRB_ADDR_DEV_SEL);
  wire commit = readDone && pendValid_r && keyOk;
  // only the control register takes a committed write
  wire ctrlCommit = commit && (pendAddr_r == `LRB_ADDR_EN_CTRL);

  // pending write; a second write replaces the one waiting
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pendValid_r <= 1'b0;
      pendAddr_r <= 7'h00;
      pendData_r <= 8'h00;
    end else if (softRst) begin
      pendValid_r <= 1'b0;
    end else if (!keyOk) begin
      // key lost: the waiting write is dropped
      pendValid_r <= 1'b0;
    end else if (writeDone && !selWrite) begin
      pendValid_r <= 1'b1;
      pendAddr_r <= addr_r;
      pendData_r <= dataIn_r;
    end else if (readDone) begin
      pendValid_r <= 1'b0;
    end
  end

  // select register next value
  reg [7:0] devSel_nxt;
  always @* begin
    devSel_nxt = devSel_r;
    if (softRst) begin
      // soft reset locks the port again
      devSel_nxt = `LRB_SEL_RESET;
    end else if (selWrite) begin
      devSel_nxt = dataIn_r;
    end
  end

  // select register; key check gates the port
  always @(posedge clock or negedge rstn) begin
    if (!rstn)
      devSel_r <= `LRB_SEL_RESET;
    else
      devSel_r <= devSel_nxt;
  end

  // enable/control next value; all function bits default to off
  reg [7:0] enableCtrl_nxt;
  always @* begin
    enableCtrl_nxt = enableCtrl;
    if (softRst) begin
      enableCtrl_nxt = `LRB_EN_RESET;
    end else if (ctrlCommit) begin
      // the whole pending byte is loaded; a one in bit 7 clears it all a clock later
      enableCtrl_nxt = pendData_r;
    end
  end

  // enable/control register
  always @(posedge clock or negedge rstn) begin
    if (!rstn)
      enableCtrl <= `LRB_EN_RESET;
    else
      enableCtrl <= enableCtrl_nxt;
  end

  //////////////////////////////////////////////////////////////////////
  // adc snapshot on preload rising; clear the bit to re-arm
  reg preloadDly_r;
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      preloadDly_r <= 1'b0;
      adcHold_r <= 8'h00;
    end else if (softRst) begin
      preloadDly_r <= 1'b0;
      adcHold_r <= 8'h00;
    end else begin
      preloadDly_r <= enableCtrl[`LRB_BIT_PRELOAD];
      if (enableCtrl[`LRB_BIT_PRELOAD] && !preloadDly_r)
        adcHold_r <= adcResult;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // function enables; shutdown gates driver and chip, bits stay set
  // sampler enable
  assign samplerOn = enableCtrl[`LRB_BIT_SAMPLER];
  assign adcOn = enableCtrl[`LRB_BIT_ADC];
  assign heaterOn = enableCtrl[`LRB_BIT_HEATER];
  assign driver_core_on = enableCtrl[`LRB_BIT_DRIVER] &&
                          !thermalShutdown;
  assign chipOn = enableCtrl[`LRB_BIT_CHIP] && !thermalShutdown;

  //////////////////////////////////////////////////////////////////////
  // shutdown only if enabled, one clock behind
  // follows the input level, so it lifts once cool
  always @(posedge clock or negedge rstn) begin
    if (!rstn)
      thermalShutdown <= 1'b0;
    else
      thermalShutdown <= enableCtrl[`LRB_BIT_OT_SHDN] && overTemp;
  end

  always @(posedge clock or negedge rstn) begin
    if (!rstn)
      portActive <= 1'b0;
    else
      portActive <= keyOk;
  end

endmodule

/* File: dv/lrb_host_model.sv */
// spi host model that drives mode-0 frames into the register bank
`timescale 1ns/1ps
module lrb_host_model (
  input wire clock,
  input wire spiMiso,
  output reg spiSclk,
  output reg spiCsn,
  output reg spiMosi
);
  // idle: deselected, clock parked low
  initial begin
    spiSclk = 1'b0;
    spiCsn = 1'b1;
    spiMosi = 1'b0;
  end
  // one sclk phase, six clocks, changes just after an edge
  task ph;
    begin
      repeat (6) @(posedge clock);
      #1;
    end
  endtask
  // one frame, msb first, miso taken just before each rise
  task xfer(input [15:0] f, output [7:0] d);
    integer i;
    begin
      spiCsn = 1'b0;
      for (i = 15; i >= 0; i = i - 1) begin
        spiMosi = f[i];
        ph;
        d = {d[6:0], spiMiso};
        spiSclk = 1'b1;
        ph;
        spiSclk = 1'b0;
      end
      ph;
      spiCsn = 1'b1;
      spiMosi = ~spiMosi; // released line shows no stale bit
      ph;
    end
  endtask
endmodule

/* File: dv/lrb_spi_regs_assertions.sv */
// port assertions for the select/enable register bank
`timescale 1ns/1ps
module lrb_spi_regs_chk (
  input wire clock,
  input wire rstn,
  input wire spiMisoOe,
  input wire overTemp,
  input wire samplerOn,
  input wire adcOn,
  input wire heaterOn,
  input wire driver_core_on,
  input wire chipOn,
  input wire thermalShutdown,
  input wire portActive,
  input wire [7:0] enableCtrl
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  wire tsd = thermalShutdown;
  wire [7:0] ec = enableCtrl;
  shut_follow_a:
    assert property (tsd == ($past(ec[5]) && $past(overTemp)))
    else $error("thermal shutdown wrong");
  sampler_bit_a: assert property (samplerOn == ec[4])
    else $error("sampler enable wrong");
  adc_bit_a: assert property (adcOn == ec[3])
    else $error("adc enable wrong");
  heater_bit_a: assert property (heaterOn == ec[2])
    else $error("heater enable wrong");
  driver_gate_a:
    assert property (driver_core_on == (ec[1] && !tsd))
    else $error("driver enable wrong");
  chip_gate_a: assert property (chipOn == (ec[0] && !tsd))
    else $error("chip enable wrong");
  soft_clear_a: assert property (ec[7] |=> ec == 8'h00)
    else $error("soft reset not cleared");
  locked_oe_a: assert property (spiMisoOe |-> portActive)
    else $error("miso driven while locked");
  locked_hold_a:
    assert property (!$stable(ec) |-> $past(portActive) || ec == 8'h00)
    else $error("control changed while locked");
  cover property ($rose(tsd));
  cover property (spiMisoOe);
  cover property ($fell(portActive));
endmodule
bind lrb_spi_regs lrb_spi_regs_chk chk (.clock(clock), .rstn(rstn),
  .spiMisoOe(spiMisoOe), .overTemp(overTemp), .samplerOn(samplerOn),
  .adcOn(adcOn), .heaterOn(heaterOn), .driver_core_on(driver_core_on),
  .chipOn(chipOn), .thermalShutdown(thermalShutdown),
  .portActive(portActive), .enableCtrl(enableCtrl));

/* File: dv/lrb_spi_regs_tb_top.sv */
// self-checking bench for the select/enable register bank
`timescale 1ns/1ps
module lrb_spi_regs_tb_top;
  localparam [7:0] PID = 8'h3C; // arbitrary value
  localparam [7:0] REV = 8'hC3; // arbitrary value
  reg clock = 1'b0;
  reg rstn = 1'b0;
  reg [7:0] adcResult = 8'h00;
  reg overTemp = 1'b0;
  wire spiSclk, spiCsn, spiMosi, spiMiso, spiMisoOe;
  wire samplerOn, adcOn, heaterOn, driver_core_on, chipOn, tsd, act;
  wire [7:0] enableCtrl;
  wire [7:0] outs = {tsd, act, 1'b0, samplerOn, adcOn, heaterOn,
    driver_core_on, chipOn};
  integer miscompares = 0;
  integer checked = 0;
  reg [7:0] rv;
  integer oeCnt = 0;
  // clocks on which the device drives miso
  always @(posedge clock) if (spiMisoOe) oeCnt <= oeCnt + 1;
  always #2.5 clock = ~clock;
  lrb_host_model host (.clock(clock), .spiMiso(spiMiso),
    .spiSclk(spiSclk), .spiCsn(spiCsn), .spiMosi(spiMosi));
  lrb_spi_regs #(.PART_ID(PID), .SI_REV(REV)) uut (.clock(clock),
    .rstn(rstn), .spiSclk(spiSclk), .spiCsn(spiCsn), .spiMosi(spiMosi),
    .spiMiso(spiMiso), .spiMisoOe(spiMisoOe), .adcResult(adcResult),
    .overTemp(overTemp), .enableCtrl(enableCtrl), .samplerOn(samplerOn),
    .adcOn(adcOn), .heaterOn(heaterOn), .driver_core_on(driver_core_on),
    .chipOn(chipOn), .thermalShutdown(tsd), .portActive(act));
  task chk(input [7:0] got, input [7:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wr(input [6:0] a, input [7:0] d);
    host.xfer({1'b0, a, d}, rv);
  endtask
  task rc(input [6:0] a, input [7:0] e);
    begin
      host.xfer({1'b1, a, 8'h00}, rv);
      chk(rv, e);
    end
  endtask
  task finish_test;
    begin
      $display("checked=%0d miscompares=%0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  // hang guard
  initial begin
    #200000;
    miscompares = miscompares + 1;
    finish_test;
  end
  // main sequence
  initial begin
    repeat (6) @(posedge clock);
    #1 rstn = 1'b1;
    repeat (4) @(posedge clock);
    #1 chk(outs, 8'h00);
    rc(7'h00, 8'h00);
    wr(7'h07, 8'h01);
    rc(7'h00, 8'h00);
    chk(enableCtrl, 8'h00);
    chk(oeCnt[7:0], 8'h00);
    $display("test locked done");
    wr(7'h03, 8'h03);
    chk(outs, 8'h40);
    rc(7'h00, PID);
    rc(7'h01, REV);
    chk({7'h00, oeCnt != 0}, 8'h01);
    wr(7'h07, 8'h3F);
    chk(enableCtrl, 8'h00);
    rc(7'h03, 8'h03);
    chk(outs, 8'h5F);
    overTemp = 1'b1;
    repeat (3) @(posedge clock);
    #1 chk(outs, 8'hDC);
    overTemp = 1'b0;
    wr(7'h00, 8'hFF);
    rc(7'h00, PID);
    $display("test enables done");
    adcResult = 8'h96;
    wr(7'h07, 8'h7F);
    rc(7'h01, REV);
    adcResult = 8'h11;
    rc(7'h43, 8'h96);
    wr(7'h07, 8'h3F);
    rc(7'h07, 8'h7F);
    chk(enableCtrl, 8'h3F);
    $display("test preload done");
    wr(7'h07, 8'h80);
    rc(7'h00, PID);
    chk(outs, 8'h00);
    wr(7'h03, 8'h03);
    rc(7'h07, 8'h00);
    wr(7'h03, 8'h05);
    chk(outs, 8'h00);
    rc(7'h00, 8'h00);
    $display("test reset and key done");
    finish_test;
  end
endmodule
